// ### rtl/pm_mux_pkg.sv
/*
 * constants for the power-management pin function mux.
 * assumes a single 100 MHz system clock and active-low async reset.
 */
// Summary of operation
// RULE1: event two polarity set by config bit
// RULE2: shared pin event input or dma ack bit1
// RULE3: reset default selects event and battery inputs
// RULE4: suspend input requests smi, always resumes; code resumes only while suspend_active_i
// RULE5: no ide: indicator low during suspend
// RULE6: ide strap: pin enables command buffer
// RULE7: select gp io 0 or master request
// RULE8: select gp io 1 or zero wait input
// RULE9: compact isa enable drives command strobe
// RULE10: select gp io 2 or full speed flag
// RULE11: select bit makes pin at clock source
// RULE12: select bit drives address buffer enable
// RULE13: select gp io 3 or stop grant input
// RULE14: latch strobe captures twelve power controls
// RULE15: strobe pulses during reset to preset latch
// RULE16: configure shared master pin as ring indicator; code takes ring only from ring_or_select_n_i, with compact_isa_en_i off
// RULE17: compact isa off: ring input resumes system
// RULE18: peripheral asserts select after address decode
// RULE19: select may suppress isa command lines
// RULE20: backoff between cycles becomes interrupt
// RULE21: clock run restarts stopped at clock
// RULE22: all async pin inputs synchronised first
package pm_mux_pkg;
    // reset value of the pin-select bit (event inputs, not dma ack)
    localparam logic dma_ack_sel_rst = 1'b0;
    // reset preset pulse length in clocks
    localparam int preset_pulse_cycles = 4;
    // number of peripheral power controls
    localparam int power_ctl_width = 12;
    // synchroniser indices
    localparam int sync_event_two = 0;
    localparam int sync_susp = 1;
    localparam int sync_ring = 2;
    localparam int sync_select = 3;
    localparam int sync_backoff = 4;
    localparam int sync_clock_run_request_n = 5;
    localparam int sync_grant = 6;
    localparam int sync_zws = 7;
    localparam int sync_local_master_request_n = 8;
    localparam int sync_width = 9;
endpackage : pm_mux_pkg

// ### rtl/pm_pin_function_mux.sv
/*
 * power-management and miscellaneous pin function mux.
 * assumes config bits come from registers on sys_clk_i; pins are async.
 */
`timescale 1ns/1ns
module pm_pin_function_mux #(
    parameter int PRESET_CYCLES = pm_mux_pkg::preset_pulse_cycles,
    parameter int PWR_W = pm_mux_pkg::power_ctl_width
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // configuration bits
    input wire logic event_two_invert_i,
    input wire logic dma_ack_pin_sel_i,
    input wire logic master_req_sel_i,
    input wire logic zero_wait_sel_i,
    input wire logic full_speed_sel_i,
    input wire logic at_clk_src_sel_i,
    input wire logic addr_buf_sel_i,
    input wire logic stop_grant_sel_i,
    input wire logic compact_isa_en_i,
    input wire logic cmd_suppress_en_i,
    input wire logic ide_strap_i,
    // internal state from other blocks
    input wire logic suspend_active_i,
    input wire logic cpu_full_speed_i,
    input wire logic encoded_dma_ack_bit1_i,
    input wire logic ide_cmd_buffer_enable_i,
    input wire logic addr_buffer_in_use_i,
    input wire logic compact_cmd_i,
    input wire logic local_master_request_i,
    input wire logic stop_clock_broadcast_done_i,
    input wire logic power_latch_req_i,
    input wire logic [PWR_W-1:0] power_ctl_value_i,
    input wire logic [3:0] gp_io_out_i,
    input wire logic [3:0] gp_io_oe_i,
    // pins in
    input wire logic ext_pm_event_two_i,
    input wire logic suspend_resume_in_i,
    input wire logic ring_or_select_n_i,
    input wire logic [3:0] gp_io_pin_i,
    input wire logic at_clock_source_in_i,
    // pins out
    output logic ext_pm_event_two_oe_o,
    output logic encoded_dma_ack_bit1_o,
    output logic suspend_indicator_n_o,
    output logic [3:0] gp_io_pin_o,
    output logic [3:0] gp_io_pin_oe_o,
    output logic addr_buffer_enable_n_o,
    output logic periph_power_latch_strobe_o,
    output logic [PWR_W-1:0] memory_address_lines_o,
    // decoded status toward other blocks
    output logic pm_event_two_o,
    output logic suspend_smi_req_o,
    output logic resume_req_o,
    output logic zero_wait_state_o,
    output logic stop_clock_grant_o,
    output logic at_clock_source_o,
    output logic local_master_req_in_o,
    output logic [3:0] gp_io_in_o,
    output logic isa_cmd_inhibit_o,
    output logic backoff_irq_o,
    output logic at_clock_run_o
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers

    localparam int SW = pm_mux_pkg::sync_width;
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_s;
    logic [3:0] gp_s;

    // gather async pins
    always_comb begin
        pins_raw = '1;
        pins_raw[pm_mux_pkg::sync_event_two] = ext_pm_event_two_i;
        pins_raw[pm_mux_pkg::sync_susp] = suspend_resume_in_i;
        pins_raw[pm_mux_pkg::sync_ring] = ring_or_select_n_i;
        pins_raw[pm_mux_pkg::sync_select] = ring_or_select_n_i;
        pins_raw[pm_mux_pkg::sync_backoff] = ring_or_select_n_i;
        pins_raw[pm_mux_pkg::sync_clock_run_request_n] = ring_or_select_n_i;
        pins_raw[pm_mux_pkg::sync_grant] = gp_io_pin_i[3];
        pins_raw[pm_mux_pkg::sync_zws] = gp_io_pin_i[1];
        pins_raw[pm_mux_pkg::sync_local_master_request_n] = gp_io_pin_i[0];
    end

    // RULE22: async pin synchronisers
    pm_sync #(
        .WIDTH(SW),
        .RESET_VAL({SW{1'b1}})
    ) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    // RULE22: gp io and at clock source synchronisers
    logic at_src_s;
    pm_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h00)
    ) u_gp_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i({at_clock_source_in_i, gp_io_pin_i}),
        .sync_o({at_src_s, gp_s})
    );

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [2:0] {
        LATCH_PRESET = 3'b001,
        LATCH_IDLE = 3'b010,
        LATCH_PULSE = 3'b100
    } latch_state_t;

    typedef struct packed {
        latch_state_t latch_st;
        logic [7:0] preset_cnt;
        logic strobe;
        logic [PWR_W-1:0] ma;
        logic sel_prev;
        logic cmd_inhibit;
        logic backoff_irq;
        logic clock_run;
        logic at_clk_stopped;
        logic susp_prev;
        logic smi_req;
        logic resume;
        logic ring_prev;
    } mux_state_t;

    mux_state_t state_r;
    mux_state_t state_nxt;

    logic sel_n;
    logic ring_n;
    assign sel_n = pins_s[pm_mux_pkg::sync_select];
    assign ring_n = pins_s[pm_mux_pkg::sync_ring];

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        state_nxt = state_r;
        state_nxt.smi_req = 1'b0;
        state_nxt.resume = 1'b0;
        state_nxt.backoff_irq = 1'b0;
        state_nxt.clock_run = 1'b0;
        state_nxt.susp_prev = pins_s[pm_mux_pkg::sync_susp];
        state_nxt.ring_prev = ring_n;
        state_nxt.sel_prev = sel_n;

        // RULE15: preset pulse after reset, then RULE14 latch strobes
        case (state_r.latch_st)
            LATCH_PRESET: begin
                state_nxt.strobe = 1'b1;
                state_nxt.ma = '0;
                if (state_r.preset_cnt == 8'(PRESET_CYCLES - 1)) begin
                    state_nxt.latch_st = LATCH_IDLE;
                    state_nxt.strobe = 1'b0;
                end else begin
                    state_nxt.preset_cnt = state_r.preset_cnt + 8'h01;
                end
            end
            LATCH_IDLE: begin
                state_nxt.strobe = 1'b0;
                if (power_latch_req_i) begin
                    state_nxt.ma = power_ctl_value_i;
                    state_nxt.latch_st = LATCH_PULSE;
                end
            end
            LATCH_PULSE: begin
                // data set up one cycle before the strobe
                state_nxt.strobe = 1'b1;
                state_nxt.latch_st = LATCH_IDLE;
            end
            default: begin
                state_nxt.latch_st = LATCH_IDLE;
                state_nxt.strobe = 1'b0;
            end
        endcase

        // RULE4: suspend falling edge asks smi, any edge resumes while suspend_active_i
        if (state_r.susp_prev && !pins_s[pm_mux_pkg::sync_susp]) begin
            state_nxt.smi_req = 1'b1;
        end
        if (state_r.susp_prev != pins_s[pm_mux_pkg::sync_susp] && suspend_active_i) begin
            state_nxt.resume = 1'b1;
        end

        // RULE17: ring indicator resumes from suspend
        if (!compact_isa_en_i && state_r.ring_prev && !ring_n && suspend_active_i) begin
            state_nxt.resume = 1'b1;
        end

        if (compact_isa_en_i) begin
            // RULE19: select held low inhibits command lines
            state_nxt.cmd_inhibit = cmd_suppress_en_i && !sel_n && !compact_cmd_i;
            // RULE20: backoff falling edge between cycles
            if (state_r.sel_prev && !sel_n && !compact_cmd_i) begin
                state_nxt.backoff_irq = 1'b1;
            end
            // RULE21: clock run restarts stopped at clock
            if (state_r.at_clk_stopped && !pins_s[pm_mux_pkg::sync_clock_run_request_n]) begin
                state_nxt.at_clk_stopped = 1'b0;
                state_nxt.clock_run = 1'b1;
            end
            // a fresh broadcast outranks a restart in the same cycle
            if (stop_clock_broadcast_done_i) begin
                state_nxt.at_clk_stopped = 1'b1;
            end
        end else begin
            state_nxt.cmd_inhibit = 1'b0;
            state_nxt.at_clk_stopped = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= '{latch_st: LATCH_PRESET, preset_cnt: 8'h00, strobe: 1'b1,
                         ma: '0, sel_prev: 1'b1, cmd_inhibit: 1'b0,
                         backoff_irq: 1'b0, clock_run: 1'b0, at_clk_stopped: 1'b0,
                         susp_prev: 1'b1, smi_req: 1'b0, resume: 1'b0,
                         ring_prev: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin muxing

    // RULE3: shared pins stay event inputs until the preset ends
    logic dma_sel_eff;
    assign dma_sel_eff = (state_r.latch_st == LATCH_PRESET) ? pm_mux_pkg::dma_ack_sel_rst :
        dma_ack_pin_sel_i;

    // RULE1: event two polarity
    assign pm_event_two_o = !dma_sel_eff &&
        (pins_s[pm_mux_pkg::sync_event_two] ^ event_two_invert_i);
    // RULE2: dma ack bit1 drive when selected
    assign ext_pm_event_two_oe_o = dma_sel_eff;
    assign encoded_dma_ack_bit1_o = dma_sel_eff & encoded_dma_ack_bit1_i;

    // RULE5: suspend indication, RULE6: ide buffer enable
    assign suspend_indicator_n_o = ide_strap_i ? ide_cmd_buffer_enable_i : !suspend_active_i;

    // gp io pin drive per function
    always_comb begin
        gp_io_pin_o = gp_io_out_i;
        gp_io_pin_oe_o = gp_io_oe_i;
        // RULE7: master request on pin 0
        if (master_req_sel_i) begin
            gp_io_pin_o[0] = !local_master_request_i;
            gp_io_pin_oe_o[0] = local_master_request_i;
        end
        // RULE9: compact command strobe, RULE8: zero wait input
        if (compact_isa_en_i) begin
            gp_io_pin_o[1] = !compact_cmd_i;
            gp_io_pin_oe_o[1] = 1'b1;
        end else if (zero_wait_sel_i) begin
            gp_io_pin_o[1] = 1'b1;
            gp_io_pin_oe_o[1] = 1'b0;
        end
        // RULE10: full speed flag, RULE11: at clock source input
        if (at_clk_src_sel_i) begin
            gp_io_pin_o[2] = 1'b0;
            gp_io_pin_oe_o[2] = 1'b0;
        end else if (full_speed_sel_i) begin
            gp_io_pin_o[2] = cpu_full_speed_i;
            gp_io_pin_oe_o[2] = 1'b1;
        end
        // RULE13: stop grant input
        if (stop_grant_sel_i) begin
            gp_io_pin_o[3] = 1'b1;
            gp_io_pin_oe_o[3] = 1'b0;
        end
    end

    assign gp_io_in_o = gp_s;
    assign local_master_req_in_o = master_req_sel_i && !pins_s[pm_mux_pkg::sync_local_master_request_n];
    assign zero_wait_state_o = !compact_isa_en_i && zero_wait_sel_i &&
        !pins_s[pm_mux_pkg::sync_zws];
    assign stop_clock_grant_o = stop_grant_sel_i && !pins_s[pm_mux_pkg::sync_grant];
    assign at_clock_source_o = at_clk_src_sel_i && at_src_s;

    // RULE12: address buffer enable when in use
    assign addr_buffer_enable_n_o = addr_buf_sel_i ? !addr_buffer_in_use_i : 1'b1;

    // registered event and latch outputs
    assign periph_power_latch_strobe_o = state_r.strobe;
    assign memory_address_lines_o = state_r.ma;
    assign suspend_smi_req_o = state_r.smi_req;
    assign resume_req_o = state_r.resume;
    assign isa_cmd_inhibit_o = state_r.cmd_inhibit;
    assign backoff_irq_o = state_r.backoff_irq;
    assign at_clock_run_o = state_r.clock_run;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_preset_strobe: assert property (@(posedge sys_clk_i) // RULE15
        $rose(reset_n_i) |-> periph_power_latch_strobe_o)
        else $error("latch strobe not high after reset");
    a_latch_capture: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE14
        (state_r.latch_st == LATCH_IDLE && power_latch_req_i) |=> ##1
        (periph_power_latch_strobe_o && memory_address_lines_o == $past(power_ctl_value_i, 2)))
        else $error("latch strobe missing value");
    a_event_polarity: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE1
        !dma_sel_eff |-> pm_event_two_o ==
        (pins_s[pm_mux_pkg::sync_event_two] ^ event_two_invert_i))
        else $error("event two polarity wrong");
    a_dma_ack_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE2
        dma_sel_eff |-> ext_pm_event_two_oe_o && !pm_event_two_o)
        else $error("dma ack pin not driven");
    a_suspend_ind: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE5
        !ide_strap_i |-> suspend_indicator_n_o == !suspend_active_i)
        else $error("suspend indicator wrong");
    a_smi_request: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE4
        $fell(pins_s[pm_mux_pkg::sync_susp]) |=> suspend_smi_req_o)
        else $error("suspend smi missing");
    a_ring_resume: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE17
        (!compact_isa_en_i && suspend_active_i && $fell(ring_n)) |=> resume_req_o)
        else $error("ring resume missing");
    a_clock_restart: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE21
        (compact_isa_en_i && state_r.at_clk_stopped && !pins_s[pm_mux_pkg::sync_clock_run_request_n])
        |=> at_clock_run_o && state_r.at_clk_stopped == $past(stop_clock_broadcast_done_i))
        else $error("clock run ignored");
    a_gp_default: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE13
        stop_grant_sel_i |-> !gp_io_pin_oe_o[3])
        else $error("grant pin driven");
    a_reset_default: assert property (@(posedge sys_clk_i) // RULE3
        state_r.latch_st == LATCH_PRESET |-> !ext_pm_event_two_oe_o && !encoded_dma_ack_bit1_o)
        else $error("shared pins left the event default");
    a_backoff_irq: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // RULE20
        (compact_isa_en_i && !compact_cmd_i && $fell(sel_n)) |=> backoff_irq_o)
        else $error("backoff interrupt missing");
endmodule // pm_pin_function_mux

// ### rtl/pm_sync.sv
/*
 * two-flop synchroniser bank for asynchronous pin inputs.
 * assumes inputs come from pins outside the clock domain.
 */
`timescale 1ns/1ns
module pm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_r;
    sync_state_t state_nxt;

    // shift through two stages
    always_comb begin
        state_nxt.meta = async_i;
        state_nxt.stable = state_r.meta;
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= {RESET_VAL, RESET_VAL};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign sync_o = state_r.stable;
endmodule // pm_sync

// ### testbench/pm_far_side.sv
/*
 * far-side model: external peripheral power latch and the shared select pin.
 * assumes the strobe comes from the mux and the pin claim from the bench.
 */
`timescale 1ns/1ns
module pm_far_side (
    // from the mux
    input wire logic strobe_i,
    input wire logic [11:0] lines_i,
    // from the bench
    input wire logic claim_i,
    // pin side
    output logic ring_or_select_n_o,
    output logic [11:0] latched_o
);
    // latch follows the lines while the strobe is high
    always_latch begin
        if (strobe_i) begin
            latched_o <= lines_i;
        end
    end
    // ring line pulled up unless a peripheral claims it
    assign ring_or_select_n_o = claim_i ? 1'h0 : 1'h1;
endmodule // pm_far_side

// ### testbench/test_pm_pin_function_mux.sv
/*
 * self-checking bench for the pin function mux.
 * assumes the far-side model is compiled before this file.
 */
`timescale 1ns/1ns
module test_pm_pin_function_mux;
    typedef struct packed {
        logic [11:0] in;
        logic [6:0] exp;
    } row_t;
    logic sys_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic inv, dma_sel, ms_sel, zw_sel, fs_sel, atc_sel, ab_sel, sg_sel, compact_isa_bus, supp, ide;
    logic susp_act, cpu_fs, dack1, ide_buf, in_use, cmd, bcast, mreq, latch_req, claim;
    logic ev_pin, susp_pin, atc_pin, sel_n;
    logic ev_oe, dack_o, ind_n, ab_n, strobe, pm_ev, system_mgmt_interrupt, rsm, zws, sgnt, atc, bko, crun, inh;
    logic [11:0] pwr_val, ma, latched;
    logic [3:0] gp_out, gp_oe, gp_pin_i, gp_pin_o, gp_oe_pin, gp_in;
    logic mreq_in;
    logic [6:0] got;
    int bad_count = 0;
    int n_compared = 0;
    int n_smi, n_rsm, n_bko, n_crun, n_stb;
    logic [11:0] words [2] = '{12'ha5c, 12'h3a6};
    row_t rows [4] = '{'{12'b1001_0110_1010, 7'b111_00x0}, '{12'b0111_1011_0011, 7'b0101111},
        '{12'b1010_1110_1101, 7'b1010001}, '{12'b0100_0011_0100, 7'b00011x0}};

    pm_pin_function_mux dut_u (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .event_two_invert_i(inv), .dma_ack_pin_sel_i(dma_sel), .master_req_sel_i(ms_sel),
        .zero_wait_sel_i(zw_sel), .full_speed_sel_i(fs_sel), .at_clk_src_sel_i(atc_sel),
        .addr_buf_sel_i(ab_sel), .stop_grant_sel_i(sg_sel), .compact_isa_en_i(compact_isa_bus),
        .cmd_suppress_en_i(supp), .ide_strap_i(ide), .suspend_active_i(susp_act),
        .cpu_full_speed_i(cpu_fs), .encoded_dma_ack_bit1_i(dack1),
        .ide_cmd_buffer_enable_i(ide_buf), .addr_buffer_in_use_i(in_use), .compact_cmd_i(cmd),
        .local_master_request_i(mreq), .stop_clock_broadcast_done_i(bcast),
        .power_latch_req_i(latch_req), .power_ctl_value_i(pwr_val), .gp_io_out_i(gp_out),
        .gp_io_oe_i(gp_oe), .ext_pm_event_two_i(ev_pin), .suspend_resume_in_i(susp_pin),
        .ring_or_select_n_i(sel_n), .gp_io_pin_i(gp_pin_i), .at_clock_source_in_i(atc_pin),
        .ext_pm_event_two_oe_o(ev_oe), .encoded_dma_ack_bit1_o(dack_o),
        .suspend_indicator_n_o(ind_n), .gp_io_pin_o(gp_pin_o), .gp_io_pin_oe_o(gp_oe_pin),
        .addr_buffer_enable_n_o(ab_n), .periph_power_latch_strobe_o(strobe),
        .memory_address_lines_o(ma), .pm_event_two_o(pm_ev), .suspend_smi_req_o(system_mgmt_interrupt),
        .resume_req_o(rsm), .zero_wait_state_o(zws), .stop_clock_grant_o(sgnt),
        .at_clock_source_o(atc), .local_master_req_in_o(mreq_in), .gp_io_in_o(gp_in),
        .isa_cmd_inhibit_o(inh), .backoff_irq_o(bko), .at_clock_run_o(crun)
    );

    pm_far_side far_u (
        .strobe_i(strobe), .lines_i(ma), .claim_i(claim),
        .ring_or_select_n_o(sel_n), .latched_o(latched)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock and pulse counters
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        n_smi += system_mgmt_interrupt;
        n_rsm += rsm;
        n_bko += bko;
        n_crun += crun;
        n_stb += strobe;
    end

    // compare one bit
    task automatic check_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask

    // compare a word or a count
    task automatic check_word(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // wait falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // clear pulse counters
    task automatic zero_counts();
        n_smi = 0;
        n_rsm = 0;
        n_bko = 0;
        n_crun = 0;
        n_stb = 0;
    endtask

    // verdict and end of run
    task final_report();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #20000;
        bad_count++;
        final_report();
    end

    // main sequence
    initial begin
        {inv, dma_sel, ms_sel, zw_sel, fs_sel, atc_sel, ab_sel, sg_sel, compact_isa_bus, supp, ide} = '0;
        {susp_act, cpu_fs, dack1, ide_buf, in_use, cmd, bcast, mreq, latch_req, claim} = '0;
        {ev_pin, atc_pin, pwr_val, gp_out} = '0;
        susp_pin = 1'h1;
        gp_pin_i = 4'hf;
        gp_oe = 4'hf;
        {dma_sel, dack1} = 2'h3;
        zero_counts();
        cyc(3);
        check_bit("event pin default", 1'h0, ev_oe);
        check_bit("dma ack default", 1'h0, dack_o);
        {dma_sel, dack1} = 2'h0;
        check_bit("strobe in reset", 1'h1, strobe);
        check_word("address in reset", 12'h000, ma);
        cyc(13);
        reset_n_i = 1'h1;
        cyc(3);
        check_bit("strobe preset", 1'h1, strobe);
        cyc(3);
        check_bit("strobe idle", 1'h0, strobe);
        check_word("latch preset", 12'h000, latched);
        foreach (rows[i]) begin
            gp_out = {4{rows[i].in[11]}};
            {cmd, compact_isa_bus, cpu_fs, fs_sel, in_use, ab_sel, ide_buf, susp_act, ide, dack1, dma_sel} =
                rows[i].in[10:0];
            #1;
            got = {gp_pin_o[0], gp_pin_o[2], gp_pin_o[1], ab_n, ind_n, dack_o, ev_oe};
            for (int k = 0; k < 7; k++) begin
                if (rows[i].exp[k] !== 1'hx) begin
                    check_bit($sformatf("row %0d out %0d", i, k), rows[i].exp[k], got[k]);
                end
            end
            cyc(1);
        end
        {compact_isa_bus, susp_act, cmd} = '0;
        ev_pin = 1'h1;
        cyc(4);
        check_bit("event plain", 1'h1, pm_ev);
        inv = 1'h1;
        cyc(4);
        check_bit("event inverted", 1'h0, pm_ev);
        {zw_sel, sg_sel, atc_sel, atc_pin} = 4'hf;
        gp_pin_i = 4'h0;
        cyc(4);
        check_bit("zero wait", 1'h1, zws);
        check_bit("stop grant", 1'h1, sgnt);
        check_bit("at clock source", 1'h1, atc);
        check_word("gp inputs", 12'h000, {8'h00, gp_in});
        check_word("pin enables", 12'h001, {8'h00, gp_oe_pin});
        {ms_sel, mreq} = 2'h3;
        cyc(3);
        check_bit("master request pin", 1'h0, gp_pin_o[0]);
        check_bit("master request drive", 1'h1, gp_oe_pin[0]);
        check_bit("master request in", 1'h1, mreq_in);
        {ms_sel, mreq} = 2'h0;
        gp_pin_i = 4'hf;
        zero_counts();
        susp_pin = 1'h0;
        cyc(6);
        check_word("smi pulses", 12'h001, 12'(n_smi));
        check_word("resume awake", 12'h000, 12'(n_rsm));
        susp_act = 1'h1;
        zero_counts();
        susp_pin = 1'h1;
        cyc(6);
        check_word("resume pulses", 12'h001, 12'(n_rsm));
        check_word("smi on rise", 12'h000, 12'(n_smi));
        zero_counts();
        claim = 1'h1;
        cyc(6);
        check_word("ring resume", 12'h001, 12'(n_rsm));
        claim = 1'h0;
        compact_isa_bus = 1'h1;
        cyc(4);
        zero_counts();
        claim = 1'h1;
        cyc(6);
        check_word("backoff pulses", 12'h001, 12'(n_bko));
        check_word("ring off", 12'h000, 12'(n_rsm));
        check_word("run not stopped", 12'h000, 12'(n_crun));
        check_bit("inhibit off", 1'h0, inh);
        supp = 1'h1;
        cyc(2);
        check_bit("inhibit on", 1'h1, inh);
        claim = 1'h0;
        cyc(5);
        check_bit("inhibit released", 1'h0, inh);
        bcast = 1'h1;
        cyc(1);
        bcast = 1'h0;
        zero_counts();
        claim = 1'h1;
        cyc(6);
        check_word("clock run pulses", 12'h001, 12'(n_crun));
        claim = 1'h0;
        foreach (words[i]) begin
            zero_counts();
            pwr_val = words[i];
            latch_req = 1'h1;
            cyc(1);
            latch_req = 1'h0;
            cyc(4);
            check_word("latched word", words[i], latched);
            check_word("strobe cycles", 12'h001, 12'(n_stb));
        end
        reset_n_i = 1'h0;
        cyc(2);
        check_bit("strobe second reset", 1'h1, strobe);
        reset_n_i = 1'h1;
        cyc(8);
        check_bit("strobe after reset", 1'h0, strobe);
        final_report();
    end
endmodule // test_pm_pin_function_mux
